/* File: srw_top.sv */
// Supply reset and watchdog supervisor output logic.
// Assumes i_mclk is a free-running internal timebase; inputs are async pins.
`timescale 1ns/1ns
module srw_top #(
	parameter int unsigned HOLD_CYC = srw_pkg::RST_HOLD_CYC,
	parameter int unsigned WDOG_CYC = srw_pkg::WDOG_CYC
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_supply_low,
	input wire logic i_manual_rst_n,
	input wire logic i_wdog_kick_in,
	input wire logic i_wdog_kick_driven,
	output logic o_rst_n,
	output logic o_rst,
	output logic o_wdog_timeout_n
);
	srw_sync_if supply_if ();
	srw_sync_if mrst_if ();
	srw_sync_if kick_if ();
	srw_sync_if drv_if ();

	logic supply_low_s;
	logic manual_rst_n_s;
	logic kick_s;
	logic wdog_en_s;
	logic assert_cond;
	logic rst_act_r;
	logic [srw_pkg::CNT_W-1:0] hold_cnt_r;
	logic kick_prev_r;
	logic kick_edge;
	logic wd_clear;
	logic [srw_pkg::CNT_W-1:0] wd_cnt_r;
	logic [srw_pkg::CNT_W-1:0] wd_cnt_nxt;
	logic wdo_n_r;
	logic [srw_pkg::CNT_W-1:0] ref_hold_r;
	logic [srw_pkg::CNT_W-1:0] ref_idle_r;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisation
	assign supply_if.raw = i_supply_low;
	assign mrst_if.raw = i_manual_rst_n;
	assign kick_if.raw = i_wdog_kick_in;
	assign drv_if.raw = i_wdog_kick_driven;

	srw_sync3 #(.RST_VAL(srw_pkg::SUPPLY_LOW_RST_VAL)) u_sync_supply (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.pin(supply_if.sync)
	);
	srw_sync3 #(.RST_VAL(srw_pkg::MRST_RST_VAL)) u_sync_mrst (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.pin(mrst_if.sync)
	);
	srw_sync3 #(.RST_VAL(srw_pkg::KICK_RST_VAL)) u_sync_kick (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.pin(kick_if.sync)
	);
	srw_sync3 #(.RST_VAL(srw_pkg::DRIVEN_RST_VAL)) u_sync_drv (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.pin(drv_if.sync)
	);

	assign supply_low_s = supply_if.filt;
	assign manual_rst_n_s = mrst_if.filt;
	assign kick_s = kick_if.filt;
	assign wdog_en_s = drv_if.filt;

	////////////////////////////////////////////////////////////////////////
	// Reset generator
	assign assert_cond = supply_low_s | ~manual_rst_n_s;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_act_r <= 1'b1;
			hold_cnt_r <= '0;
		end else if (assert_cond) begin
			rst_act_r <= 1'b1;
			hold_cnt_r <= '0;
		end else if (rst_act_r) begin
			if (hold_cnt_r == srw_pkg::CNT_W'(HOLD_CYC - 1)) begin
				rst_act_r <= 1'b0;
				hold_cnt_r <= '0;
			end else begin
				hold_cnt_r <= hold_cnt_r + 1'b1;
			end
		end
	end

	assign o_rst_n = ~rst_act_r;
	assign o_rst = rst_act_r;

	////////////////////////////////////////////////////////////////////////
	// Watchdog
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			kick_prev_r <= srw_pkg::KICK_RST_VAL;
		end else begin
			kick_prev_r <= kick_s;
		end
	end

	assign kick_edge = kick_s ^ kick_prev_r;
	assign wd_clear = supply_low_s | ~wdog_en_s | kick_edge;

	always_comb begin
		if (wd_clear) begin
			wd_cnt_nxt = '0;
		end else if (wd_cnt_r == srw_pkg::CNT_W'(WDOG_CYC)) begin
			wd_cnt_nxt = wd_cnt_r;
		end else begin
			wd_cnt_nxt = wd_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wd_cnt_r <= '0;
			wdo_n_r <= 1'b1;
		end else begin
			wd_cnt_r <= wd_cnt_nxt;
			// Low on supply loss or when the count reaches the period
			wdo_n_r <= ~supply_low_s & (wd_cnt_nxt != srw_pkg::CNT_W'(WDOG_CYC));
		end
	end

	assign o_wdog_timeout_n = wdo_n_r;

	////////////////////////////////////////////////////////////////////////
	// Reference counters for the checks
	// Cycles since the reset cause last cleared, saturating at the hold length
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ref_hold_r <= '0;
		end else if (assert_cond) begin
			ref_hold_r <= '0;
		end else if (ref_hold_r != srw_pkg::CNT_W'(HOLD_CYC)) begin
			ref_hold_r <= ref_hold_r + 1'h1;
		end
	end

	// Cycles since the last kick edge, saturating at the period
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ref_idle_r <= '0;
		end else if (kick_edge) begin
			ref_idle_r <= '0;
		end else if (ref_idle_r != srw_pkg::CNT_W'(WDOG_CYC)) begin
			ref_idle_r <= ref_idle_r + 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	a_rst_on_cond: assert property (assert_cond |=> !o_rst_n)
		else $error("reset not asserted on supply low or manual reset");
	a_rst_hold_len: assert property ($rose(o_rst_n) |-> $past(hold_cnt_r) == HOLD_CYC - 1)
		else $error("reset released before hold count expired");
	a_rst_hold_clear: assert property ($rose(o_rst_n) |-> $past(!assert_cond, 1))
		else $error("reset released while a condition was present");
	a_wdog_no_rst: assert property (o_rst_n && !assert_cond |=> o_rst_n)
		else $error("reset asserted without supply or manual cause");
	a_kick_restart: assert property (kick_edge |=> wd_cnt_r == 0)
		else $error("kick edge did not restart watchdog count");
	a_wdog_expire: assert property (
		wdog_en_s && !supply_low_s && !kick_edge && wd_cnt_r == WDOG_CYC - 1
		|=> !o_wdog_timeout_n)
		else $error("watchdog did not expire at period");
	a_wdog_period: assert property (
		$fell(o_wdog_timeout_n) && !$past(supply_low_s) |-> $past(wd_cnt_r) == WDOG_CYC - 1)
		else $error("watchdog expired at wrong count");
	a_supply_wdo: assert property (supply_low_s |=> !o_wdog_timeout_n)
		else $error("timeout output not forced low on supply loss");
	a_rst_compl: assert property (o_rst == !o_rst_n)
		else $error("reset outputs not complementary");
	a_wdog_disable: assert property (!wdog_en_s && !supply_low_s |=> o_wdog_timeout_n)
		else $error("watchdog timed out while disabled");
	a_supply_recover: assert property ($fell(supply_low_s) |-> wd_cnt_r == 0 ##1 o_wdog_timeout_n)
		else $error("watchdog not fresh after supply recovery");

	// Checks against the reference counters and restart behaviour
	a_rst_hold_ref: assert property (
		o_rst_n == (ref_hold_r == srw_pkg::CNT_W'(HOLD_CYC)))
		else $error("reset outputs disagree with reference hold count");
	a_hold_restart: assert property (assert_cond |=> hold_cnt_r == 0)
		else $error("new reset cause did not restart the hold count");
	a_rst_manual_hi: assert property (!manual_rst_n_s |=> o_rst)
		else $error("active-high reset not asserted on manual reset");
	a_wdog_no_early: assert property (
		!o_wdog_timeout_n |-> $past(supply_low_s) || wd_cnt_r == srw_pkg::CNT_W'(WDOG_CYC))
		else $error("timeout output low before the period elapsed");
	a_wdog_idle_ref: assert property (
		!o_wdog_timeout_n && !$past(supply_low_s) |-> ref_idle_r == srw_pkg::CNT_W'(WDOG_CYC))
		else $error("timeout output low although a kick edge came in time");
	a_wdog_kick_high: assert property (kick_edge && !supply_low_s |=> o_wdog_timeout_n)
		else $error("kick edge did not release the timeout output");
	a_wdog_en_clear: assert property (!wdog_en_s |=> wd_cnt_r == 0)
		else $error("watchdog count not held while kick input floats");

	// Main scenarios
	c_rst_release: cover property ($rose(o_rst_n));
	c_wdog_expire: cover property ($fell(o_wdog_timeout_n) && !supply_low_s);
	c_manual_rst: cover property ($fell(manual_rst_n_s) && o_rst_n);
	c_supply_recover: cover property ($fell(supply_low_s));
	c_hold_restart: cover property (assert_cond && rst_act_r && hold_cnt_r != 0);
endmodule

/* File: srw_pkg.sv */
// Shared constants of the supply reset and watchdog supervisor.
// Assumes a single 10 MHz system clock.
package srw_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	// Reset hold time, ms
	localparam int unsigned RST_HOLD_MIN_MS = 140;
	localparam int unsigned RST_HOLD_TYP_MS = 200;
	localparam int unsigned RST_HOLD_MAX_MS = 280;
	localparam int unsigned RST_HOLD_CYC = RST_HOLD_TYP_MS * CYC_PER_MS;
	// Watchdog period, ms
	localparam int unsigned WDOG_MIN_MS = 1000;
	localparam int unsigned WDOG_TYP_MS = 1600;
	localparam int unsigned WDOG_MAX_MS = 2250;
	localparam int unsigned WDOG_CYC = WDOG_TYP_MS * CYC_PER_MS;
	localparam int unsigned CNT_W = 32;
	// Synchroniser reset levels
	localparam logic MRST_RST_VAL = 1'b1;
	localparam logic SUPPLY_LOW_RST_VAL = 1'b1;
	localparam logic KICK_RST_VAL = 1'b0;
	localparam logic DRIVEN_RST_VAL = 1'b0;
endpackage

/* File: srw_sync_if.sv */
// Carrier between a pin synchroniser and the supervisor core.
// Raw pin level in, asynchronous to i_mclk; filtered level out on i_mclk.
`timescale 1ns/1ns
interface srw_sync_if;
	logic raw;
	logic filt;
	modport sync (input raw, output filt);
	modport core (output raw, input filt);
endinterface

/* File: srw_sync3.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes the raw input is asynchronous to i_mclk.
`timescale 1ns/1ns
module srw_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	srw_sync_if.sync pin
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic filt_r;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else begin
			s1_r <= pin.raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Change taken once stages two and three agree
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			filt_r <= RST_VAL;
		end else if (s2_r == s3_r) begin
			filt_r <= s3_r;
		end
	end

	assign pin.filt = filt_r;
endmodule

/* File: srw_host_model.sv */
// Host model: kicks the watchdog, drives manual reset, may loop timeout back.
// Assumes stimulus changes at rising edges of i_mclk.
`timescale 1ns/1ns
module srw_host_model #(
	parameter int unsigned KICK_GAP = 10
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_wdog_timeout_n,
	input wire logic i_kick_en,
	input wire logic i_kick_run,
	input wire logic i_loop_en,
	input wire logic i_button_n,
	output logic o_wdog_kick_in,
	output logic o_wdog_kick_driven,
	output logic o_manual_rst_n
);
	logic kick_r = 1'b0;
	int unsigned gap_r = 0;
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n || !i_kick_en || !i_kick_run) begin
			gap_r <= 0;
		end else if (gap_r == KICK_GAP - 1) begin
			gap_r <= 0;
			kick_r <= ~kick_r;
		end else begin
			gap_r <= gap_r + 1;
		end
	end
	// Floating pin shows the inverse of the last driven level
	assign o_wdog_kick_in = i_kick_en ? kick_r : ~kick_r;
	assign o_wdog_kick_driven = i_kick_en;
	assign o_manual_rst_n = i_button_n & (i_loop_en ? i_wdog_timeout_n : 1'b1);
endmodule

/* File: test_supply_reset_watchdog.sv */
// Self-checking bench for the supervisor with a host model.
// Assumes shortened hold and watchdog counts set by parameter.
`timescale 1ns/1ns
module test_supply_reset_watchdog;
	localparam int unsigned HOLD = 20;
	localparam int unsigned WD = 50;
	localparam int unsigned GAP = 10;
	logic i_mclk = 0, i_reset_n = 0, supply_low = 0, button_n = 1;
	logic kick_en = 1, kick_run = 0, loop_en = 0;
	logic kick, driven, manual_n, o_rst_n, o_rst, o_wdog_timeout_n;
	int err_count = 0, cmp_count = 0, n;
	always #50 i_mclk = ~i_mclk;
	srw_top #(.HOLD_CYC(HOLD), .WDOG_CYC(WD)) uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_supply_low(supply_low), .i_manual_rst_n(manual_n), .i_wdog_kick_in(kick),
		.i_wdog_kick_driven(driven), .o_rst_n(o_rst_n), .o_rst(o_rst),
		.o_wdog_timeout_n(o_wdog_timeout_n));
	srw_host_model #(.KICK_GAP(GAP)) host (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_wdog_timeout_n(o_wdog_timeout_n), .i_kick_en(kick_en), .i_kick_run(kick_run),
		.i_loop_en(loop_en), .i_button_n(button_n), .o_wdog_kick_in(kick),
		.o_wdog_kick_driven(driven), .o_manual_rst_n(manual_n));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %b seen %b", nm, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_mclk);
		#1;
	endtask
	task automatic until_rst_hi();
		n = 0;
		while (o_rst_n !== 1'b1 && n < 300) begin cyc(1); n++; end
	endtask
	task automatic until_wd_lo();
		n = 0;
		while (o_wdog_timeout_n !== 1'b0 && n < 300) begin cyc(1); n++; end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(negedge i_mclk) if (i_reset_n) chk("rst_pair", 1'b1, o_rst ^ o_rst_n);
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_manual();
		@(posedge i_mclk) button_n <= 0;
		cyc(6);
		chk("rst_n_manual", 1'b0, o_rst_n);
		@(posedge i_mclk) button_n <= 1;
		until_rst_hi();
		chk("hold_manual", 1'b1, n >= HOLD + 2 && n <= HOLD + 7);
	endtask
	task automatic t_supply();
		@(posedge i_mclk) supply_low <= 1;
		cyc(6);
		chk("rst_n_supply", 1'b0, o_rst_n);
		chk("wd_supply", 1'b0, o_wdog_timeout_n);
		@(posedge i_mclk) supply_low <= 0;
		cyc(6);
		chk("wd_recover", 1'b1, o_wdog_timeout_n);
		until_rst_hi();
		chk("hold_supply", 1'b1, n >= HOLD - 4 && n <= HOLD + 1);
	endtask
	task automatic t_wdog();
		logic bad;
		bad = 0;
		repeat (3 * WD) begin cyc(1); bad |= (o_wdog_timeout_n !== 1'b1); end
		chk("wd_kicked_low", 1'b0, bad);
		@(posedge i_mclk) kick_run <= 0;
		until_wd_lo();
		chk("wd_period", 1'b1, n >= WD - GAP && n <= WD + 6);
		chk("rst_n_wd", 1'b1, o_rst_n);
		@(posedge i_mclk) kick_run <= 1;
		cyc(GAP + 6);
		chk("wd_rekick", 1'b1, o_wdog_timeout_n);
	endtask
	task automatic t_loop();
		@(posedge i_mclk) loop_en <= 1;
		kick_run <= 0;
		until_wd_lo();
		cyc(6);
		chk("rst_n_loop", 1'b0, o_rst_n);
		@(posedge i_mclk) kick_run <= 1;
		until_rst_hi();
		chk("rst_n_loop_end", 1'b1, o_rst_n);
		@(posedge i_mclk) loop_en <= 0;
	endtask
	task automatic t_float();
		@(posedge i_mclk) kick_en <= 0;
		cyc(3 * WD);
		chk("wd_float", 1'b1, o_wdog_timeout_n);
		@(posedge i_mclk) kick_en <= 1;
		cyc(4);
	endtask
	task automatic t_start();
		repeat (20) @(posedge i_mclk);
		i_reset_n <= 1;
		kick_run <= 1;
		cyc(1);
		chk("rst_n_start", 1'b0, o_rst_n);
		until_rst_hi();
		chk("hold_start", 1'b1, n >= HOLD && n <= HOLD + 8);
	endtask
	initial begin
		t_start();
		t_manual();
		t_supply();
		t_wdog();
		t_loop();
		t_float();
		wrap_up();
	end
	initial begin
		#300000;
		err_count++;
		wrap_up();
	end
endmodule
